// *** autoneg_status_pkg.sv ***
/*
 * Constants for the auto-negotiation partner page and expansion status registers:
 * register offsets, field positions and reset values.
 * Assumes a 5-bit management register address and 16-bit register data.
 */
package autoneg_status_pkg;

	localparam int unsigned ADDR_W = 5;
	localparam int unsigned DATA_W = 16;

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [4:0] PARTNER_PAGE_OFFSET = 5'h05;
	localparam logic [4:0] EXPANSION_OFFSET    = 5'h06;

	////////////////////////////////////////////////////////////////////////////////
	// partner_next_page_word fields
	localparam int unsigned FURTHER_PAGE_BIT = 15;
	localparam int unsigned PARTNER_ACK_BIT  = 14;
	localparam int unsigned MESSAGE_PAGE_BIT = 13;
	localparam int unsigned COMPLY_BIT       = 12;
	localparam int unsigned TOGGLE_BIT       = 11;
	localparam int unsigned CODE_MSB         = 10;
	localparam int unsigned CODE_LSB         = 0;

	////////////////////////////////////////////////////////////////////////////////
	// autoneg_expansion_status fields
	localparam int unsigned EXP_RSVD_MSB          = 15;
	localparam int unsigned EXP_RSVD_LSB          = 5;
	localparam int unsigned PD_FAULT_BIT          = 4;
	localparam int unsigned PARTNER_NEXT_PAGE_BIT = 3;
	localparam int unsigned LOCAL_NEXT_PAGE_BIT   = 2;
	localparam int unsigned PAGE_RECEIVED_BIT     = 1;
	localparam int unsigned PARTNER_AN_BIT        = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [15:0] PARTNER_PAGE_RESET    = 16'h0000;
	localparam logic [10:0] CODE_RESET            = 11'h000;
	localparam logic        LOCAL_NEXT_PAGE_VALUE = 1'h1;
	localparam logic        STATUS_BIT_RESET      = 1'h0;
	localparam logic [15:0] READ_ZERO             = 16'h0000;

endpackage

// *** partner_page_store.sv ***
/*
 * Holding register for the next page word received from the link partner.
 * Assumes the arbitration logic pulses load for one cycle with the word on load_word.
 */
`timescale 1ns/1ps
`default_nettype none

module partner_page_store
	import autoneg_status_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        ce,
	input  wire logic        load,
	input  wire logic [15:0] load_word,
	input  wire logic        tx_toggle_prev,
	output logic      [15:0] word
);

	logic [15:0] next_word;

	always_comb begin
		next_word = word;
		if (load) begin
			next_word = load_word;
			// Toggle reads as the opposite of the last sent toggle
			next_word[TOGGLE_BIT] = ~tx_toggle_prev;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			word <= PARTNER_PAGE_RESET;
		end else if (ce) begin
			word <= next_word;
		end
	end

endmodule

`default_nettype wire

// *** autoneg_partner_page_status_regs.sv ***
/*
 * Read-only auto-negotiation partner next page and expansion status registers.
 * Assumes the management frame logic presents one-cycle read and write strobes with
 * a register address, and the arbitration logic supplies received pages and status levels.
 */
`timescale 1ns/1ps
`default_nettype none

module autoneg_partner_page_status_regs
	import autoneg_status_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        ce,
	input  wire logic [4:0]  reg_addr,
	input  wire logic        reg_rd,
	input  wire logic        reg_wr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	output logic             reg_rd_valid,
	input  wire logic        page_strobe,
	input  wire logic [15:0] page_word,
	input  wire logic        tx_toggle_prev,
	input  wire logic        parallel_detect_fault,
	input  wire logic        partner_next_page_capable,
	input  wire logic        partner_autoneg_capable
);

	////////////////////////////////////////////////////////////////////////////////
	// Received page word

	logic [15:0] partner_next_page_word;

	// Only the negotiation side loads this; the write strobe has no path here
	partner_page_store page_store (
		.clock          (clock),
		.nrst           (nrst),
		.ce             (ce),
		.load           (page_strobe),
		.load_word      (page_word),
		.tx_toggle_prev (tx_toggle_prev),
		.word           (partner_next_page_word)
	);

	// Field views of the stored word
	logic        further_page_request;
	logic        partner_ack;
	logic        message_page_flag;
	logic        partner_can_comply;
	logic [10:0] page_code;

	assign further_page_request = partner_next_page_word[FURTHER_PAGE_BIT];
	assign partner_ack          = partner_next_page_word[PARTNER_ACK_BIT];
	assign message_page_flag    = partner_next_page_word[MESSAGE_PAGE_BIT];
	assign partner_can_comply   = partner_next_page_word[COMPLY_BIT];
	assign page_code            = partner_next_page_word[CODE_MSB:CODE_LSB];

	////////////////////////////////////////////////////////////////////////////////
	// Expansion status state

	logic pd_fault;
	logic partner_paging;
	logic partner_an;
	logic page_received;
	logic next_pd_fault;
	logic next_partner_paging;
	logic next_partner_an;
	logic next_page_received;
	logic exp_read;

	assign exp_read = reg_rd && (reg_addr == EXPANSION_OFFSET);

	always_comb begin
		next_pd_fault       = parallel_detect_fault;
		next_partner_paging = partner_next_page_capable;
		next_partner_an     = partner_autoneg_capable;
		// A page landing in the read cycle survives the clear
		next_page_received  = page_strobe || (page_received && !exp_read);
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			pd_fault       <= STATUS_BIT_RESET;
			partner_paging <= STATUS_BIT_RESET;
			partner_an     <= STATUS_BIT_RESET;
			page_received  <= STATUS_BIT_RESET;
		end else if (ce) begin
			pd_fault       <= next_pd_fault;
			partner_paging <= next_partner_paging;
			partner_an     <= next_partner_an;
			page_received  <= next_page_received;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path

	function automatic logic [15:0] expansion_word(
		input logic fault,
		input logic paging,
		input logic received,
		input logic an
	);
		logic [15:0] w;
		w = READ_ZERO;
		w[PD_FAULT_BIT]          = fault;
		w[PARTNER_NEXT_PAGE_BIT] = paging;
		w[LOCAL_NEXT_PAGE_BIT]   = LOCAL_NEXT_PAGE_VALUE;
		w[PAGE_RECEIVED_BIT]     = received;
		w[PARTNER_AN_BIT]        = an;
		return w;
	endfunction

	logic [15:0] next_rdata;
	logic        next_rd_valid;

	// reg_wdata is deliberately unused: every field is read-only
	always_comb begin
		next_rdata    = reg_rdata;
		next_rd_valid = 1'b0;
		if (reg_rd) begin
			next_rd_valid = 1'b1;
			unique case (reg_addr)
				PARTNER_PAGE_OFFSET: next_rdata = partner_next_page_word;
				EXPANSION_OFFSET:    next_rdata = expansion_word(pd_fault, partner_paging, page_received, partner_an);
				default:             next_rdata = READ_ZERO;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			reg_rdata    <= READ_ZERO;
			reg_rd_valid <= 1'b0;
		end else if (ce) begin
			reg_rdata    <= next_rdata;
			reg_rd_valid <= next_rd_valid;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	a_page_flag_sets: assert property (@(posedge clock) disable iff (!nrst)
		ce && page_strobe |=> page_received)
		else $error("page flag not set after page strobe");

	a_page_flag_clears: assert property (@(posedge clock) disable iff (!nrst)
		ce && exp_read && !page_strobe |=> !page_received)
		else $error("page flag not cleared by read");

	a_page_flag_sticky: assert property (@(posedge clock) disable iff (!nrst)
		page_received && !(ce && exp_read) |=> page_received)
		else $error("page flag dropped without a read");

	a_read_sees_flag: assert property (@(posedge clock) disable iff (!nrst)
		ce && exp_read |=> reg_rd_valid && reg_rdata[PAGE_RECEIVED_BIT] == $past(page_received))
		else $error("read did not return flag before clearing");

	a_exp_fixed_bits: assert property (@(posedge clock) disable iff (!nrst)
		ce && exp_read |=> reg_rdata[EXP_RSVD_MSB:EXP_RSVD_LSB] == 11'h000 && reg_rdata[LOCAL_NEXT_PAGE_BIT])
		else $error("reserved bits nonzero or local next page bit clear");

	a_toggle_inverse: assert property (@(posedge clock) disable iff (!nrst)
		ce && page_strobe |=> partner_next_page_word[TOGGLE_BIT] == !$past(tx_toggle_prev))
		else $error("toggle bit not inverse of sent toggle");

	a_write_ignored: assert property (@(posedge clock) disable iff (!nrst)
		reg_wr && !page_strobe |=> $stable(partner_next_page_word))
		else $error("write altered page word");

	a_page_read_data: assert property (@(posedge clock) disable iff (!nrst)
		ce && reg_rd && reg_addr == PARTNER_PAGE_OFFSET |=> reg_rdata == $past(partner_next_page_word))
		else $error("page word read mismatch");

	a_status_follows: assert property (@(posedge clock) disable iff (!nrst)
		ce && nrst |=> pd_fault == $past(parallel_detect_fault) && partner_paging == $past(partner_next_page_capable)
			&& partner_an == $past(partner_autoneg_capable))
		else $error("status bits do not follow negotiation inputs");

	// Field views must carry what the partner sent, not just mirror the store
	a_further_capture: assert property (@(posedge clock) disable iff (!nrst)
		ce && page_strobe && page_word[FURTHER_PAGE_BIT] |=> further_page_request)
		else $error("further page request not captured");

	a_ack_capture: assert property (@(posedge clock) disable iff (!nrst)
		ce && page_strobe && page_word[PARTNER_ACK_BIT] |=> partner_ack)
		else $error("partner acknowledge not captured");

	a_message_capture: assert property (@(posedge clock) disable iff (!nrst)
		ce && page_strobe && !page_word[MESSAGE_PAGE_BIT] |=> !message_page_flag)
		else $error("unformatted page shown as message page");

	a_comply_capture: assert property (@(posedge clock) disable iff (!nrst)
		ce && page_strobe && page_word[COMPLY_BIT] |=> partner_can_comply)
		else $error("comply bit not captured");

	a_code_reset: assert property (@(posedge clock)
		!nrst && ce |=> page_code == CODE_RESET)
		else $error("code field not cleared by reset");

	a_frozen_state: assert property (@(posedge clock) disable iff (!nrst)
		!ce |=> $stable(page_received) && $stable(reg_rd_valid))
		else $error("state moved while clock enable low");

endmodule

`default_nettype wire

// *** mgmt_ctrl_model.sv ***
/*
 * Station management controller model: register read and write cycles on the strobe bus.
 * Assumes a free running clock; a read answer is awaited for up to four cycles past the first, and the wait is returned.
 */
`timescale 1ns/1ps
`default_nettype none

module mgmt_ctrl_model (
	input  wire logic        clock,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_rd_valid,
	output logic      [4:0]  reg_addr,
	output logic             reg_rd,
	output logic             reg_wr,
	output logic      [15:0] reg_wdata
);
	int n;

	initial begin
		reg_addr = 5'h00;
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_wdata = 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One strobe cycle; writes are legal but the block is read-only
	task automatic xfer(input logic wr, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q,
		output int waits);
		@(posedge clock);
		reg_rd <= ~wr;
		reg_wr <= wr;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_rd <= 1'b0;
		reg_wr <= 1'b0;
		// Released lines carry the inverse so a stale value cannot pass as an answer
		reg_addr <= ~a;
		reg_wdata <= ~d;
		#1;
		for (n = 0; n < 4 && !wr && reg_rd_valid !== 1'b1; n++) begin
			@(posedge clock);
			#1;
		end
		waits = n;
		q = reg_rdata;
	endtask
endmodule

`default_nettype wire

// *** autoneg_partner_page_status_regs_bench.sv ***
/*
 * Self-checking bench for the partner page and expansion status registers.
 * Expects the register block to answer reads one cycle after the strobe.
 */
`timescale 1ns/1ps
`default_nettype none

module autoneg_partner_page_status_regs_bench import autoneg_status_pkg::*;;
	logic        clock;
	logic        nrst;
	logic        ce;
	logic [4:0]  reg_addr;
	logic        reg_rd;
	logic        reg_wr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic        reg_rd_valid;
	logic        page_strobe;
	logic [15:0] page_word;
	logic        tx_toggle_prev;
	logic        parallel_detect_fault;
	logic        partner_next_page_capable;
	logic        partner_autoneg_capable;
	int          fail_count = 0;
	int          cmp_count = 0;

	autoneg_partner_page_status_regs u_dut (.clock(clock), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rd_valid(reg_rd_valid), .page_strobe(page_strobe), .page_word(page_word),
		.tx_toggle_prev(tx_toggle_prev), .parallel_detect_fault(parallel_detect_fault),
		.partner_next_page_capable(partner_next_page_capable),
		.partner_autoneg_capable(partner_autoneg_capable));

	mgmt_ctrl_model u_mgmt (.clock(clock), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
		.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata));

	////////////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("Checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string nm);
		logic [15:0] q;
		int          w;
		u_mgmt.xfer(1'b0, a, 16'h0000, q, w);
		cmp_count++;
		if (q !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, q);
		end
		// The answer is due one cycle after the strobe, never later
		cmp_count++;
		if (w != 0) begin
			fail_count++;
			$display("Error %s answer delay expected 0 seen %0d", nm, w);
		end
	endtask

	// Writes are discarded, so no read answer may follow them
	task automatic wr(input logic [4:0] a);
		logic [15:0] q;
		int          w;
		u_mgmt.xfer(1'b1, a, 16'hFFFF, q, w);
		cmp_count++;
		if (reg_rd_valid !== 1'b0) begin
			fail_count++;
			$display("Error write answer expected 0 seen %b", reg_rd_valid);
		end
	endtask

	task automatic page(input logic [15:0] w, input logic t);
		@(posedge clock);
		page_strobe <= 1'b1;
		page_word <= w;
		tx_toggle_prev <= t;
		@(posedge clock);
		page_strobe <= 1'b0;
		page_word <= ~w;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// Whole run is under two hundred cycles, so this only fires on a hang
	initial begin
		#100000;
		fail_count++;
		test_done();
	end

	initial begin
		nrst = 1'b0;
		ce = 1'b1;
		page_strobe = 1'b0;
		page_word = 16'h0000;
		tx_toggle_prev = 1'b0;
		parallel_detect_fault = 1'b0;
		partner_next_page_capable = 1'b0;
		partner_autoneg_capable = 1'b0;
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		rd(PARTNER_PAGE_OFFSET, PARTNER_PAGE_RESET, "page reset");
		rd(EXPANSION_OFFSET, 16'h0004, "expansion reset");
		page(16'hB5A5, 1'b1);
		rd(PARTNER_PAGE_OFFSET, 16'hB5A5, "page one");
		page(16'h4A5A, 1'b1);
		rd(PARTNER_PAGE_OFFSET, 16'h425A, "page two");
		rd(EXPANSION_OFFSET, 16'h0006, "flag set");
		rd(EXPANSION_OFFSET, 16'h0004, "flag cleared");
		// New page lands in the very cycle the read is taken
		fork
			rd(EXPANSION_OFFSET, 16'h0004, "read with page");
			begin
				@(posedge clock);
				page_strobe <= 1'b1;
				@(posedge clock);
				page_strobe <= 1'b0;
			end
		join
		rd(EXPANSION_OFFSET, 16'h0006, "set over clear");
		@(posedge clock);
		parallel_detect_fault <= 1'b1;
		partner_next_page_capable <= 1'b1;
		partner_autoneg_capable <= 1'b1;
		rd(EXPANSION_OFFSET, 16'h001D, "status high");
		@(posedge clock);
		parallel_detect_fault <= 1'b0;
		partner_next_page_capable <= 1'b0;
		partner_autoneg_capable <= 1'b0;
		rd(EXPANSION_OFFSET, 16'h0004, "status low");
		// A page offered while the clock enable is low must leave no trace
		@(posedge clock);
		ce <= 1'b0;
		page(16'h8001, 1'b0);
		@(posedge clock);
		ce <= 1'b1;
		rd(EXPANSION_OFFSET, 16'h0004, "frozen flag");
		rd(PARTNER_PAGE_OFFSET, 16'hB5A5, "frozen page");
		wr(PARTNER_PAGE_OFFSET);
		wr(EXPANSION_OFFSET);
		rd(PARTNER_PAGE_OFFSET, 16'hB5A5, "page after write");
		rd(EXPANSION_OFFSET, 16'h0004, "expansion after write");
		rd(5'h1F, READ_ZERO, "unmapped");
		page(16'h0123, 1'b0);
		rd(PARTNER_PAGE_OFFSET, 16'h0923, "page three");
		@(posedge clock);
		nrst <= 1'b0;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		rd(PARTNER_PAGE_OFFSET, PARTNER_PAGE_RESET, "page second reset");
		rd(EXPANSION_OFFSET, 16'h0004, "expansion second reset");
		test_done();
	end
endmodule

`default_nettype wire
